/* pkg/link_pkg.sv */
// constants and types for the drive serial link datapath
// assumes a single 200 MHz system clock domain
package link_pkg;
  // link framing bytes
  localparam logic [7:0] SYNC_BYTE = 8'hA5;
  localparam logic [7:0] FRAME_START = 8'h7E;
  localparam logic [7:0] FRAME_END = 8'h81;
  localparam int BYTE_W = 8;
  // command memory
  localparam int CMD_DEPTH = 64;
  localparam int CMD_AW = 6;
  // command length field: low two bits of opcode give extra bytes
  localparam int LEN_LSB = 0;
  localparam int LEN_W = 2;
  // sampling period for panel switches, in cycles
  localparam int SAMPLE_US = 1;
  localparam int CLK_MHZ = 200;
  localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
  // spindle speed measurement window, in cycles (1 ms)
  localparam int SPEED_MS = 1;
  localparam int SPEED_CYC = SPEED_MS * CLK_MHZ * 1000;
  localparam int TRACKS_PER_CYL = 4;
  localparam int CYL_SHIFT = 2;
  localparam int PANEL_N = 5;
  // pll reference selection
  typedef enum logic [1:0] {
    PLL_LOCAL = 2'h0,
    PLL_WRITE = 2'h1,
    PLL_READ = 2'h3
  } pll_sel_t;
  // deframer states, gray along the path
  typedef enum logic [1:0] {
    RX_HUNT = 2'h0,
    RX_SYNCED = 2'h1,
    RX_BODY = 2'h3
  } rx_state_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_SYNC = 2'h1,
    TX_START = 2'h3,
    TX_BODY = 2'h2
  } tx_state_t;
endpackage

/* pkg/cmd_mem_if.sv */
// write/read port bundle between deframer and command memory
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface cmd_mem_if #(parameter int AW = 6, parameter int DW = 8);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data,
    output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data,
    input rd_addr, output rd_data);
endinterface

/* rtl/cmd_mem.sv */
// command byte memory with registered read data
// assumes writes and reads on the same clock
`timescale 1ns/10ps
module cmd_mem #(
  parameter int DEPTH = 64
) (
  input wire logic clk_sys,
  cmd_mem_if.mem port
);
  logic [7:0] store [DEPTH];
  logic [7:0] rd_r;

  // write then registered read
  always_ff @(posedge clk_sys) begin
    if (port.wr_en) begin
      store[port.wr_addr] <= port.wr_data;
    end
    rd_r <= store[port.rd_addr];
  end
  assign port.rd_data = rd_r;
endmodule

/* rtl/tree_codec.sv */
// two-thirds rate tree encoder and decoder pair
// assumes nrz bits arrive on a 2-bit group strobe
`timescale 1ns/10ps
module tree_codec (
  input wire logic clk_sys,
  input wire logic sys_rst,
  // encoder side
  input wire logic enc_stb,
  input wire logic [1:0] enc_nrz,
  output logic [2:0] enc_code,
  // decoder side
  input wire logic dec_stb,
  input wire logic [2:0] dec_code,
  output logic [1:0] dec_nrz
);
  // maps each 2-bit branch to a 3-bit tree leaf
  function automatic logic [2:0] enc_f(input logic [1:0] d);
    case (d)
      2'h0: enc_f = 3'h1;
      2'h1: enc_f = 3'h2;
      2'h2: enc_f = 3'h4;
      default: enc_f = 3'h5;
    endcase
  endfunction

  function automatic logic [1:0] dec_f(input logic [2:0] c);
    case (c)
      3'h2: dec_f = 2'h1;
      3'h4: dec_f = 2'h2;
      3'h5: dec_f = 2'h3;
      default: dec_f = 2'h0;
    endcase
  endfunction

  // encoder output register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      enc_code <= 3'h0;
    end else if (enc_stb) begin
      enc_code <= enc_f(enc_nrz);
    end
  end

  // decoder output register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dec_nrz <= 2'h0;
    end else if (dec_stb) begin
      dec_nrz <= dec_f(dec_code);
    end
  end
endmodule

/* rtl/disk_serial_link_datapath.sv */
// drive-side serial link framer, command gatherer and data path
// assumes link, switch, sensor, pulse and bipolar pins arrive asynchronous and are synchronised here; control inputs are not
`timescale 1ns/10ps
// Overview of operation
// - deframe link bytes, drop sync and frame bytes, store commands
// - frame responses with sync and frame bytes, send serially
// - writes convert bipolar link data to nrz
// - reads convert nrz back to bipolar link data
// - count remaining bytes per command, release only when complete
// - write nrz passes the two-thirds tree encoder
// - read pulses pass the two-thirds tree decoder
// - pll follows local clock idle, write clock, or read data
// - sample panel switches periodically, drive lights independently
// - sample cover interlock, inhibit spin-up while cover open
// - report home switch to processor and power-down logic
// - derive spindle speed from encoder pulse train
// - four tracks form one logical cylinder
module disk_serial_link_datapath
  import link_pkg::*;
#(
  parameter int SPEED_WIN = SPEED_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // serial link receive and transmit
  input wire logic link_rx,
  output logic link_tx,
  // response byte input
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic rsp_last,
  output logic rsp_ready,
  // command output to processor
  output logic cmd_ready,
  output logic [CMD_AW-1:0] cmd_len,
  input wire logic cmd_ack,
  input wire logic [CMD_AW-1:0] cmd_rd_addr,
  output logic [7:0] cmd_rd_data,
  // write and read data path
  input wire logic wr_active,
  input wire logic rd_active,
  input wire logic [1:0] wr_bipolar,
  output logic [2:0] wr_code,
  input wire logic [2:0] rd_pulse,
  output logic [1:0] rd_bipolar,
  output logic [1:0] pll_sel,
  // panel, interlock, home, spindle
  input wire logic [PANEL_N-1:0] panel_sw,
  input wire logic [PANEL_N-1:0] panel_light_set,
  output logic [PANEL_N-1:0] panel_sw_state,
  output logic [PANEL_N-1:0] panel_light,
  input wire logic cover_open,
  input wire logic spin_req,
  output logic spin_enable,
  input wire logic home_sw,
  output logic home_cpu,
  output logic home_pwr,
  input wire logic spindle_enc,
  output logic [15:0] spindle_speed,
  // address mapping
  input wire logic [12:0] track_addr,
  output logic [10:0] cyl_addr,
  output logic [1:0] cyl_track
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int SN = 2 + PANEL_N + 3 + 3 + 2;
  logic [SN-1:0] s1_r, s2_r;
  logic rx_s, enc_s, cov_s, home_s;
  logic [PANEL_N-1:0] sw_s;
  logic [2:0] pulse_s;
  logic [1:0] bip_s;

  // two stages before any logic looks
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= {link_rx, spindle_enc, panel_sw, cover_open, home_sw,
        1'b0, rd_pulse, wr_bipolar};
      s2_r <= s1_r;
    end
  end
  assign {rx_s, enc_s, sw_s, cov_s, home_s} = s2_r[SN-1:SN-PANEL_N-4];
  assign pulse_s = s2_r[4:2];
  assign bip_s = s2_r[1:0];

  // ----------------------------------------------------------------
  // receive deserialiser and deframer
  // ----------------------------------------------------------------
  cmd_mem_if #(.AW(CMD_AW), .DW(8)) mif ();
  rx_state_t rx_st_r;
  logic [7:0] rx_sh_r;
  logic [2:0] rx_cnt_r;
  logic rx_byte_r;
  logic [CMD_AW-1:0] wptr_r, start_r;
  logic [LEN_W-1:0] need_r;
  logic first_r;

  // shift in bits; before sync every bit is a candidate alignment
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_sh_r <= 8'h00;
      rx_cnt_r <= 3'h0;
      rx_byte_r <= 1'b0;
    end else begin
      rx_sh_r <= {rx_sh_r[6:0], rx_s};
      rx_cnt_r <= (rx_st_r == RX_HUNT) ? 3'h0 : rx_cnt_r + 3'h1;
      rx_byte_r <= (rx_st_r != RX_HUNT) && (rx_cnt_r == 3'h7);
    end
  end

  // frame recognition and command storage
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_st_r <= RX_HUNT;
      wptr_r <= '0;
      start_r <= '0;
      need_r <= '0;
      first_r <= 1'b0;
      cmd_ready <= 1'b0;
      cmd_len <= '0;
    end else begin
      if (cmd_ack) begin
        cmd_ready <= 1'b0;
      end
      case (rx_st_r)
        RX_HUNT: begin
          if ({rx_sh_r[6:0], rx_s} == SYNC_BYTE) begin
            rx_st_r <= RX_SYNCED;
          end
        end
        RX_SYNCED: begin
          if (rx_byte_r) begin
            if (rx_sh_r == FRAME_START) begin
              rx_st_r <= RX_BODY;
              wptr_r <= start_r;
              first_r <= 1'b1;
            end else begin
              rx_st_r <= RX_HUNT;
            end
          end
        end
        RX_BODY: begin
          if (rx_byte_r) begin
            if (rx_sh_r == FRAME_END) begin
              // short sequence is malformed and dropped
              if (!first_r && need_r == '0) begin
                cmd_ready <= 1'b1;
                cmd_len <= wptr_r - start_r;
                start_r <= wptr_r;
              end
              rx_st_r <= RX_HUNT;
            end else begin
              wptr_r <= wptr_r + 1'b1;
              first_r <= 1'b0;
              if (first_r) begin
                need_r <= rx_sh_r[LEN_LSB +: LEN_W];
              end else if (need_r != '0) begin
                need_r <= need_r - 1'b1;
              end
            end
          end
        end
        default: rx_st_r <= RX_HUNT;
      endcase
    end
  end
  assign mif.wr_en = (rx_st_r == RX_BODY) && rx_byte_r &&
    (rx_sh_r != FRAME_END);
  assign mif.wr_addr = wptr_r;
  assign mif.wr_data = rx_sh_r;
  assign mif.rd_addr = cmd_rd_addr;
  assign cmd_rd_data = mif.rd_data;

  cmd_mem #(.DEPTH(CMD_DEPTH)) u_mem (
    .clk_sys(clk_sys),
    .port(mif.mem)
  );

  // ----------------------------------------------------------------
  // response framer and serialiser
  // ----------------------------------------------------------------
  tx_state_t tx_st_r;
  logic [7:0] tx_sh_r;
  logic [2:0] tx_cnt_r;
  logic tx_last_r, tx_endq_r;

  // sync, start, body bytes, end byte, one bit a cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_st_r <= TX_IDLE;
      tx_sh_r <= 8'h00;
      tx_cnt_r <= 3'h0;
      tx_last_r <= 1'b0;
      tx_endq_r <= 1'b0;
      link_tx <= 1'b0;
      rsp_ready <= 1'b0;
    end else begin
      rsp_ready <= 1'b0;
      link_tx <= (tx_st_r == TX_IDLE) ? 1'b0 : tx_sh_r[7];
      tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      tx_cnt_r <= tx_cnt_r + 3'h1;
      case (tx_st_r)
        TX_IDLE: begin
          tx_cnt_r <= 3'h0;
          if (rsp_valid) begin
            tx_sh_r <= SYNC_BYTE;
            tx_st_r <= TX_SYNC;
          end
        end
        TX_SYNC: begin
          if (tx_cnt_r == 3'h7) begin
            tx_sh_r <= FRAME_START;
            tx_st_r <= TX_START;
          end
        end
        TX_START, TX_BODY: begin
          if (tx_cnt_r == 3'h7) begin
            if (tx_endq_r) begin
              tx_endq_r <= 1'b0;
              tx_st_r <= TX_IDLE;
            end else if (tx_last_r) begin
              tx_sh_r <= FRAME_END;
              tx_last_r <= 1'b0;
              tx_endq_r <= 1'b1;
            end else begin
              tx_sh_r <= rsp_byte;
              tx_last_r <= rsp_last;
              rsp_ready <= 1'b1;
              tx_st_r <= TX_BODY;
            end
          end
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // data path conversion and coding
  // ----------------------------------------------------------------
  logic wr_nrz_r, rd_nrz_q;
  logic [1:0] pair_r;
  logic half_r;
  logic [1:0] dec_nrz;
  logic [2:0] enc_code;

  // bipolar pair +1/-1 maps to one nrz bit, collected two at a time
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_nrz_r <= 1'b0;
      pair_r <= 2'h0;
      half_r <= 1'b0;
    end else if (wr_active) begin
      wr_nrz_r <= bip_s[1];
      pair_r <= {pair_r[0], wr_nrz_r};
      half_r <= ~half_r;
    end else begin
      half_r <= 1'b0;
    end
  end

  tree_codec u_codec (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .enc_stb(wr_active && half_r),
    .enc_nrz(pair_r),
    .enc_code(enc_code),
    .dec_stb(rd_active),
    .dec_code(pulse_s),
    .dec_nrz(dec_nrz)
  );
  assign rd_nrz_q = dec_nrz[0];

  // nrz back to bipolar; idle line sends zero level
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_bipolar <= 2'h0;
      wr_code <= 3'h0;
      pll_sel <= PLL_LOCAL;
    end else begin
      rd_bipolar <= rd_active ? {rd_nrz_q, ~rd_nrz_q} : 2'h0;
      wr_code <= enc_code;
      if (wr_active) begin
        pll_sel <= PLL_WRITE;
      end else if (rd_active) begin
        pll_sel <= PLL_READ;
      end else begin
        pll_sel <= PLL_LOCAL;
      end
    end
  end

  // ----------------------------------------------------------------
  // panel, interlock, home and spindle
  // ----------------------------------------------------------------
  logic [15:0] samp_cnt_r;
  logic [31:0] win_cnt_r;
  logic [15:0] edge_cnt_r;
  logic enc_d_r;

  // periodic sampling of switches; interlock registered every cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      samp_cnt_r <= 16'h0000;
      panel_sw_state <= '0;
      panel_light <= '0;
      spin_enable <= 1'b0;
      home_cpu <= 1'b0;
      home_pwr <= 1'b0;
    end else begin
      panel_light <= panel_light_set;
      spin_enable <= spin_req && !cov_s;
      home_cpu <= home_s;
      home_pwr <= home_s;
      if (samp_cnt_r == 16'(SAMPLE_CYC - 1)) begin
        samp_cnt_r <= 16'h0000;
        panel_sw_state <= sw_s;
      end else begin
        samp_cnt_r <= samp_cnt_r + 16'h0001;
      end
    end
  end

  // count encoder rising edges in a fixed window
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      win_cnt_r <= 32'h0000_0000;
      edge_cnt_r <= 16'h0000;
      enc_d_r <= 1'b0;
      spindle_speed <= 16'h0000;
    end else begin
      enc_d_r <= enc_s;
      if (win_cnt_r == 32'(SPEED_WIN - 1)) begin
        win_cnt_r <= 32'h0000_0000;
        spindle_speed <= edge_cnt_r;
        edge_cnt_r <= 16'h0000;
      end else begin
        win_cnt_r <= win_cnt_r + 32'h0000_0001;
        if (enc_s && !enc_d_r) begin
          edge_cnt_r <= edge_cnt_r + 16'h0001;
        end
      end
    end
  end

  // track number split into cylinder and track within it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cyl_addr <= 11'h000;
      cyl_track <= 2'h0;
    end else begin
      cyl_addr <= track_addr[12:CYL_SHIFT];
      cyl_track <= track_addr[CYL_SHIFT-1:0];
    end
  end
endmodule

/* verif/link_peer.sv */
// controller-side model: sends framed messages, collects framed replies
// assumes one bit per clk_sys cycle, msb first, driven at falling edge
`timescale 1ns/10ps
module link_peer
  import link_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // link pins
  output logic link_rx,
  input wire logic link_tx
);
  logic [7:0] hunt_r;
  logic in_msg;
  int nbit;
  logic [7:0] got_q[$];

  initial begin
    link_rx = 1'b0;
    hunt_r = 8'h00;
    in_msg = 1'b0;
    nbit = 0;
  end
  // one byte onto the line, msb first
  task automatic put_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(negedge clk_sys);
      link_rx = b[i];
    end
  endtask
  // framed message; start byte replaceable to force a refusal
  task automatic send(input logic [7:0] st, input logic [7:0] body[$]);
    put_byte(SYNC_BYTE);
    put_byte(st);
    foreach (body[i]) put_byte(body[i]);
    put_byte(FRAME_END);
    @(negedge clk_sys);
    link_rx = ~link_rx; // idle line shows no stale bit
  endtask
  // hunt sync on the reply line, then gather bytes up to the end byte
  always @(posedge clk_sys) begin
    hunt_r = {hunt_r[6:0], link_tx};
    if (!in_msg) begin
      if (hunt_r === SYNC_BYTE) begin
        in_msg = 1'b1;
        nbit = 0;
      end
    end else begin
      nbit++;
      if (nbit == 8) begin
        nbit = 0;
        got_q.push_back(hunt_r);
        if (hunt_r === FRAME_END) in_msg = 1'b0;
      end
    end
  end
endmodule

/* verif/link_asserts.sv */
// port checker for the drive serial link datapath
// assumes binding onto the top module, one clock domain
`timescale 1ns/10ps
module link_asserts
  import link_pkg::*;
#(
  parameter int SPEED_WIN = 100
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // handshakes
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic cmd_ready,
  input wire logic cmd_ack,
  // data path
  input wire logic wr_active,
  input wire logic rd_active,
  input wire logic [1:0] rd_bipolar,
  input wire logic [1:0] pll_sel,
  // sensors and address
  input wire logic [PANEL_N-1:0] panel_light_set,
  input wire logic [PANEL_N-1:0] panel_light,
  input wire logic cover_open,
  input wire logic spin_enable,
  input wire logic home_sw,
  input wire logic home_cpu,
  input wire logic home_pwr,
  input wire logic [12:0] track_addr,
  input wire logic [10:0] cyl_addr,
  input wire logic [1:0] cyl_track
);
  // ----------------------------------------
  // helper logic and properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  logic [8:0] open_cnt_r;
  // cycles the cover has stayed open
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !cover_open) open_cnt_r <= 9'h000;
    else if (open_cnt_r != 9'h1FF) open_cnt_r <= open_cnt_r + 9'h001;
  end
  AST_CMD_HOLD: assert property (cmd_ready && !cmd_ack |=> cmd_ready)
    else $error("command flag dropped without ack");
  AST_CMD_CLR: assert property (cmd_ready && cmd_ack |=> !cmd_ready)
    else $error("command flag kept after ack");
  AST_RSP_GAP: assert property (rsp_ready |=> !rsp_ready [*7])
    else $error("response bytes taken closer than one byte time");
  AST_RSP_VAL: assert property (rsp_ready |-> rsp_valid)
    else $error("response byte taken while none offered");
  AST_PLL_IDLE: assert property ((!sys_rst && !wr_active && !rd_active)[*4]
    |-> pll_sel == PLL_LOCAL)
    else $error("pll not on local reference when idle");
  AST_PLL_WR: assert property ((!sys_rst && wr_active && !rd_active)[*4]
    |-> pll_sel == PLL_WRITE)
    else $error("pll not on write clock during write");
  AST_PLL_RD: assert property ((!sys_rst && rd_active && !wr_active)[*4]
    |-> pll_sel == PLL_READ)
    else $error("pll not on read data during read");
  AST_RD_OFF: assert property ((!rd_active)[*4] |-> rd_bipolar == 2'h0)
    else $error("read link data active outside a read");
  AST_COVER: assert property (open_cnt_r >= 9'h1C2 |-> !spin_enable)
    else $error("spin-up allowed with cover open");
  AST_HOME: assert property ((!sys_rst && $stable(home_sw))[*5]
    |-> home_cpu == home_sw && home_pwr == home_sw)
    else $error("home indication differs from switch");
  AST_LIGHT: assert property ((!sys_rst && $stable(panel_light_set))[*4]
    |-> panel_light == panel_light_set)
    else $error("panel light not as set");
  AST_CYL: assert property ((!sys_rst && $stable(track_addr))[*4]
    |-> cyl_addr == track_addr[12:2] && cyl_track == track_addr[1:0])
    else $error("cylinder mapping wrong");
  COV_CMD: cover property ($rose(cmd_ready));
  COV_RSP: cover property (rsp_ready);
  COV_COVER: cover property (open_cnt_r == 9'h1C2);
endmodule
bind disk_serial_link_datapath link_asserts #(.SPEED_WIN(SPEED_WIN)) chk_u (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .rsp_valid(rsp_valid),
  .rsp_ready(rsp_ready), .cmd_ready(cmd_ready), .cmd_ack(cmd_ack),
  .wr_active(wr_active), .rd_active(rd_active), .rd_bipolar(rd_bipolar),
  .pll_sel(pll_sel), .panel_light_set(panel_light_set),
  .panel_light(panel_light), .cover_open(cover_open),
  .spin_enable(spin_enable), .home_sw(home_sw), .home_cpu(home_cpu),
  .home_pwr(home_pwr), .track_addr(track_addr), .cyl_addr(cyl_addr),
  .cyl_track(cyl_track));

/* verif/disk_serial_link_datapath_test.sv */
// bench for the drive serial link datapath: link, data path, sensors
// assumes link_peer on the link and the bound port checker
`timescale 1ns/10ps
module disk_serial_link_datapath_test
  import link_pkg::*;
;
  localparam int WIN = 100;
  logic clk_sys, sys_rst, link_rx, link_tx, rsp_valid, rsp_last, rsp_ready;
  logic cmd_ready, cmd_ack, wr_active, rd_active, cover_open, spin_req;
  logic spin_enable, home_sw, home_cpu, home_pwr, spindle_enc;
  logic [7:0] rsp_byte, cmd_rd_data;
  logic [5:0] cmd_len, cmd_rd_addr;
  logic [1:0] wr_bipolar, rd_bipolar, pll_sel, cyl_track;
  logic [2:0] wr_code, rd_pulse;
  logic [4:0] panel_sw, panel_light_set, panel_sw_state, panel_light;
  logic [15:0] spindle_speed;
  logic [12:0] track_addr;
  logic [10:0] cyl_addr;
  int error_cnt = 0;
  int n_tests = 0;

  disk_serial_link_datapath #(.SPEED_WIN(WIN)) dut_u (.*);
  link_peer peer_u (.clk_sys(clk_sys), .link_rx(link_rx), .link_tx(link_tx));

  // ----------------------------------------
  // clock, helpers and access tasks
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // watch a fixed window for the command flag
  task automatic wait_cmd(input int lim, output logic seen);
    seen = 1'b0;
    repeat (lim) begin
      @(negedge clk_sys);
      if (cmd_ready === 1'b1) seen = 1'b1;
    end
  endtask
  task automatic rd_cmd(input logic [5:0] a, input logic [7:0] exp);
    cmd_rd_addr = a;
    wait_n(3);
    check("cmd byte", 16'(cmd_rd_data), 16'(exp));
  endtask
  task automatic ack_cmd();
    cmd_ack = 1'b1;
    wait_n(1);
    cmd_ack = 1'b0;
    wait_n(1);
  endtask
  // offer one response byte, hold it until taken
  task automatic put_rsp(input logic [7:0] b, input logic last);
    int t;
    t = 0;
    rsp_byte = b;
    rsp_last = last;
    rsp_valid = 1'b1;
    @(posedge clk_sys);
    while (rsp_ready !== 1'b1 && t < 300) begin
      @(posedge clk_sys);
      t++;
    end
    @(negedge clk_sys);
  endtask
  // encoder pulses every ten cycles
  initial begin
    spindle_enc = 1'b0;
    forever begin
      wait_n(5);
      spindle_enc = ~spindle_enc;
    end
  end
  initial begin
    #100000;
    error_cnt++;
    $display("BAD watchdog expected end seen hang");
    test_done();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic ok;
    logic [7:0] m[$];
    logic [7:0] exp_q[$];
    {rsp_valid, rsp_last, cmd_ack, wr_active, rd_active} = 5'h00;
    {cover_open, spin_req, home_sw} = 3'h0;
    {rsp_byte, cmd_rd_addr, wr_bipolar, rd_pulse} = 19'h00000;
    {panel_sw, panel_light_set, track_addr} = 23'h000000;
    sys_rst = 1'b1;
    wait_n(3);
    sys_rst = 1'b0;
    wait_n(2);
    m = '{8'h12, 8'h34, 8'h56};
    peer_u.send(FRAME_START, m);
    wait_cmd(20, ok);
    check("ready", 16'(ok), 16'h0001);
    check("len", 16'(cmd_len), 16'h0003);
    foreach (m[i]) rd_cmd(6'(i), m[i]);
    ack_cmd();
    check("ack", 16'(cmd_ready), 16'h0000);
    peer_u.send(FRAME_START, '{8'h13, 8'h01});
    wait_cmd(40, ok);
    check("short msg", 16'(ok), 16'h0000);
    peer_u.send(8'h00, '{8'h40});
    wait_cmd(40, ok);
    check("bad start", 16'(ok), 16'h0000);
    peer_u.send(FRAME_START, '{8'h40});
    wait_cmd(20, ok);
    check("one byte", 16'(ok), 16'h0001);
    check("len1", 16'(cmd_len), 16'h0001);
    rd_cmd(6'h03, 8'h40);
    ack_cmd();
    put_rsp(8'hC3, 1'b0);
    put_rsp(8'h5A, 1'b1);
    rsp_valid = 1'b0;
    wait_n(40);
    exp_q = '{FRAME_START, 8'hC3, 8'h5A, FRAME_END};
    check("tx count", 16'(peer_u.got_q.size()), 16'h0004);
    foreach (exp_q[i]) check("tx byte", 16'(peer_u.got_q[i]), 16'(exp_q[i]));
    wr_active = 1'b1;
    wr_bipolar = 2'b10;
    wait_n(20);
    check("wr ones", 16'(wr_code), 16'h0005);
    check("pll write", 16'(pll_sel), 16'(PLL_WRITE));
    wr_bipolar = 2'b01;
    wait_n(20);
    check("wr zeros", 16'(wr_code), 16'h0001);
    wr_active = 1'b0;
    rd_active = 1'b1;
    rd_pulse = 3'b101;
    wait_n(20);
    check("rd ones", 16'(rd_bipolar), 16'h0002);
    check("pll read", 16'(pll_sel), 16'(PLL_READ));
    rd_pulse = 3'b001;
    wait_n(20);
    check("rd zeros", 16'(rd_bipolar), 16'h0001);
    rd_active = 1'b0;
    panel_sw = 5'h15;
    panel_light_set = 5'h0A;
    {cover_open, spin_req, home_sw} = 3'h7;
    track_addr = 13'h1ABD;
    wait_n(450);
    check("switch", 16'(panel_sw_state), 16'h0015);
    check("pll local", 16'(pll_sel), 16'(PLL_LOCAL));
    check("light", 16'(panel_light), 16'h000A);
    check("spin open", 16'(spin_enable), 16'h0000);
    check("home", 16'({home_cpu, home_pwr}), 16'h0003);
    check("cyl", 16'(cyl_addr), 16'h06AF);
    check("track", 16'(cyl_track), 16'h0001);
    check("speed", spindle_speed, 16'(WIN / 10));
    cover_open = 1'b0;
    home_sw = 1'b0;
    wait_n(450);
    check("spin shut", 16'(spin_enable), 16'h0001);
    check("home off", 16'({home_cpu, home_pwr}), 16'h0000);
    test_done();
  end
endmodule
